// ### udt_defs.svh
`ifndef UDT_DEFS_SVH
`define UDT_DEFS_SVH
`define UDT_CNT_W 16
`define UDT_TOP_RST 16'hFFFF
`define UDT_CMP_RST 16'h0000
`define UDT_ZERO 16'h0000
`define UDT_ONE 16'h0001
`define UDT_DIV8 11'h0007
`define UDT_DIV64 11'h003F
`define UDT_DIV256 11'h00FF
`define UDT_DIV1024 11'h03FF
`define UDT_SYNC_W 2
`endif

// ### udt_pkg.sv
package udt_pkg;
  typedef enum logic [1:0] {
    UDT_CLEAR_ON_COMPARE = 2'h0,
    UDT_WATCHDOG = 2'h1,
    UDT_FAST_PWM = 2'h2,
    UDT_PHASE_FREQ_PWM = 2'h3
  } udt_mode_t;
  typedef enum logic [1:0] {
    UDT_OUT_LOW = 2'h0,
    UDT_OUT_TOGGLE = 2'h1,
    UDT_OUT_WAVE = 2'h2,
    UDT_OUT_INV_WAVE = 2'h3
  } udt_outfn_t;
  typedef enum logic [2:0] {
    UDT_DIV_STOP = 3'h0,
    UDT_DIV_1 = 3'h1,
    UDT_DIV_8 = 3'h2,
    UDT_DIV_64 = 3'h3,
    UDT_DIV_256 = 3'h4,
    UDT_DIV_1024 = 3'h5
  } udt_div_t;
  typedef enum logic [1:0] {
    UDT_DIR_UP = 2'b01,
    UDT_DIR_DOWN = 2'b10
  } udt_dir_t;
endpackage : udt_pkg

// ### udt_src_model.sv
`timescale 1ns/1ps
module udt_src_model (
  input wire logic clk_sys,
  input wire logic run,
  output logic counter_clock_in
);
  // slow source: clock inputs are sampled, so stay well below clk_sys/2
  logic [1:0] div_r = 2'h0;
  initial counter_clock_in = 1'b0;
  always @(posedge clk_sys) begin
    if (run) begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h3) begin
        counter_clock_in <= !counter_clock_in;
      end
    end
  end
endmodule : udt_src_model

// ### udt_tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0, arst_n = 1'b0, crst_n = 1'b1, run = 1'b0;
  logic src, top_we = 1'b0, cmp_we = 1'b0, cap_en = 1'b0, trig = 1'b0;
  logic [15:0] top_d = 16'h0000, cmp_d = 16'h0000, cnt, atop, acmp, capv;
  logic [2:0] clr = 3'h0, st;
  logic wd, wave, irq, fes = 1'b0, ovf_en = 1'b1, cmp_en = 1'b1;
  udt_pkg::udt_div_t dv = udt_pkg::UDT_DIV_1;
  udt_pkg::udt_mode_t md = udt_pkg::UDT_CLEAR_ON_COMPARE;
  udt_pkg::udt_outfn_t fn = udt_pkg::UDT_OUT_WAVE;
  int fails = 0, tests_run = 0, i;
  udt_src_model udt_src_model_i (.clk_sys(clk_sys), .run(run),
    .counter_clock_in(src));
  udt_timer #(.PRELOAD_TOP(16'h0007)) udt_timer_i (.clk_sys(clk_sys),
    .arst_n(arst_n), .counter_reset_n(crst_n), .counter_clock_in(src),
    .osc_clock_in(1'b0), .use_osc(1'b0), .falling_edge_sel(fes),
    .clock_divider_select(dv), .mode_select(md), .output_function(fn),
    .shadow_top_we(top_we), .shadow_top_wdata(top_d),
    .shadow_compare_we(cmp_we), .shadow_compare_wdata(cmp_d),
    .capture_enable(cap_en), .capture_trigger(trig),
    .overflow_irq_en(ovf_en), .compare_irq_en(cmp_en),
    .capture_irq_en(1'b1),
    .status_clear(clr), .count_value(cnt), .active_top(atop),
    .active_compare(acmp), .capture_value(capv), .timer_status(st),
    .wd_expired(wd), .wave_out(wave), .timer_irq(irq));
  initial forever #12.5 clk_sys = !clk_sys;
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task chk1(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask : chk1
  task wr(input logic t, input logic [15:0] v);
    @(negedge clk_sys);
    if (t) begin top_we = 1'b1; top_d = v; end
    else begin cmp_we = 1'b1; cmp_d = v; end
    @(negedge clk_sys);
    top_we = 1'b0;
    cmp_we = 1'b0;
  endtask : wr
  task wait_cnt(input logic [15:0] v);
    for (i = 0; i < 400 && cnt !== v; i++) @(negedge clk_sys);
    chk("count reached", v, cnt);
  endtask : wait_cnt
  task pulse_clr();
    @(negedge clk_sys) clr = 3'h7;
    @(negedge clk_sys) clr = 3'h0;
  endtask : pulse_clr
  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial begin
    #(25 * 20000);
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    arst_n = 1'b1;
    chk("reset top", 16'h0007, atop);
    chk("reset count", 16'h0000, cnt);
    run = 1'b1;
    wr(1'b1, 16'h0003);
    wait_cnt(16'h0005);
    wait_cnt(16'h0000);
    repeat (3) @(negedge clk_sys);
    chk("top after wrap", 16'h0003, atop);
    chk1("ovf flag", 1'b1, st[0]);
    chk1("irq", 1'b1, irq);
    pulse_clr();
    chk("status cleared", 16'h0000, {13'h0000, st});
    ovf_en = 1'b0;
    cmp_en = 1'b0;
    wait_cnt(16'h0003);
    wait_cnt(16'h0000);
    @(negedge clk_sys) chk1("irq masked", 1'b0, irq);
    chk1("ovf pending", 1'b1, st[0]);
    ovf_en = 1'b1;
    @(negedge clk_sys) chk1("irq unmasked", 1'b1, irq);
    cmp_en = 1'b1;
    wait_cnt(16'h0002);
    dv = udt_pkg::UDT_DIV_STOP;
    md = udt_pkg::UDT_WATCHDOG;
    cap_en = 1'b1;
    repeat (20) @(negedge clk_sys);
    chk("stopped count", 16'h0002, cnt);
    trig = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk("capture", 16'h0002, capv);
    chk1("cap flag", 1'b1, st[2]);
    trig = 1'b0;
    cap_en = 1'b0;
    dv = udt_pkg::UDT_DIV_1;
    md = udt_pkg::UDT_WATCHDOG;
    crst_n = 1'b0;
    @(negedge clk_sys) chk("counter reset", 16'h0000, cnt);
    crst_n = 1'b1;
    for (i = 0; i < 100 && wd !== 1'b1; i++) @(negedge clk_sys);
    chk1("expiry strobe", 1'b1, wd);
    md = udt_pkg::UDT_FAST_PWM;
    wr(1'b0, 16'h0001);
    wait_cnt(16'h0003);
    for (int k = 0; k < 2; k++) begin
      fn = k ? udt_pkg::UDT_OUT_INV_WAVE : udt_pkg::UDT_OUT_WAVE;
      wait_cnt(16'h0000);
      wait_cnt(16'h0002);
      chk("compare loaded", 16'h0001, acmp);
      chk1("wave after cmp", !k, wave);
      wait_cnt(16'h0000);
      repeat (2) @(negedge clk_sys);
      chk1("wave after top", k, wave);
    end
    fn = udt_pkg::UDT_OUT_WAVE;
    md = udt_pkg::UDT_PHASE_FREQ_PWM;
    wr(1'b1, 16'h0004);
    wr(1'b0, 16'h0002);
    pulse_clr();
    wait_cnt(16'h0001);
    wait_cnt(16'h0000);
    repeat (3) @(negedge clk_sys);
    chk("pfc top", 16'h0004, atop);
    chk("pfc cmp", 16'h0002, acmp);
    chk1("pfc ovf", 1'b1, st[0]);
    pulse_clr();
    wait_cnt(16'h0003);
    chk1("wave up match", 1'b1, wave);
    chk1("cmp flag", 1'b1, st[1]);
    for (i = 0; i < 40 && cnt === 16'h0003; i++) @(negedge clk_sys);
    chk("turned down", 16'h0002, cnt);
    wait_cnt(16'h0001);
    chk1("wave down match", 1'b0, wave);
    fes = 1'b1;
    @(negedge src);
    repeat (3) @(negedge clk_sys);
    chk("falling edge tick", 16'h0000, cnt);
    @(posedge src);
    repeat (3) @(negedge clk_sys);
    chk("rising edge ignored", 16'h0000, cnt);
    tally_and_finish();
  end
endmodule : tb

// ### udt_tick_gen.sv
`timescale 1ns/1ps
`include "udt_defs.svh"
module udt_tick_gen (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic counter_clock_in,
  input wire logic osc_clock_in,
  input wire logic use_osc,
  input wire logic falling_edge_sel,
  input wire udt_pkg::udt_div_t clock_divider_select,
  output logic tick
);
  logic src_d_r;
  logic primed_r;
  logic src;
  logic edge_hit;
  logic [10:0] pre_r;
  logic [10:0] limit;

  function automatic logic [10:0] div_limit(input udt_pkg::udt_div_t s);
    case (s)
      udt_pkg::UDT_DIV_8: div_limit = `UDT_DIV8;
      udt_pkg::UDT_DIV_64: div_limit = `UDT_DIV64;
      udt_pkg::UDT_DIV_256: div_limit = `UDT_DIV256;
      udt_pkg::UDT_DIV_1024: div_limit = `UDT_DIV1024;
      default: div_limit = 11'h000;
    endcase
  endfunction : div_limit

  // clock inputs are sampled as synchronous levels
  assign src = use_osc ? osc_clock_in : counter_clock_in;
  assign limit = div_limit(clock_divider_select);
  // no edge until one real sample is held, whatever the idle level
  assign edge_hit = primed_r &
                    (falling_edge_sel ? (src_d_r & ~src) : (~src_d_r & src));

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      src_d_r <= 1'b0;
      primed_r <= 1'b0;
    end else begin
      src_d_r <= src;
      primed_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pre_r <= 11'h000;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      // setting zero stops the counter
      if (clock_divider_select == udt_pkg::UDT_DIV_STOP ||
          clock_divider_select > udt_pkg::UDT_DIV_1024) begin
        pre_r <= 11'h000;
      end else if (edge_hit) begin
        if (pre_r >= limit) begin
          pre_r <= 11'h000;
          tick <= 1'b1;
        end else begin
          pre_r <= pre_r + 11'h001;
        end
      end
    end
  end
endmodule : udt_tick_gen

// ### udt_timer.sv
`timescale 1ns/1ps
`include "udt_defs.svh"
module udt_timer #(
  parameter logic [15:0] PRELOAD_TOP = `UDT_TOP_RST,
  parameter logic [15:0] PRELOAD_COMPARE = `UDT_CMP_RST
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic counter_reset_n,
  input wire logic counter_clock_in,
  input wire logic osc_clock_in,
  input wire logic use_osc,
  input wire logic falling_edge_sel,
  input wire udt_pkg::udt_div_t clock_divider_select,
  input wire udt_pkg::udt_mode_t mode_select,
  input wire udt_pkg::udt_outfn_t output_function,
  input wire logic shadow_top_we,
  input wire logic [15:0] shadow_top_wdata,
  input wire logic shadow_compare_we,
  input wire logic [15:0] shadow_compare_wdata,
  input wire logic capture_enable,
  input wire logic capture_trigger,
  input wire logic overflow_irq_en,
  input wire logic compare_irq_en,
  input wire logic capture_irq_en,
  input wire logic [2:0] status_clear,
  output logic [15:0] count_value,
  output logic [15:0] active_top,
  output logic [15:0] active_compare,
  output logic [15:0] capture_value,
  output logic [2:0] timer_status,
  output logic wd_expired,
  output logic wave_out,
  output logic timer_irq
);
  logic tick;
  logic [15:0] shadow_top_r;
  logic [15:0] shadow_compare_r;
  udt_pkg::udt_dir_t dir_r;
  logic [`UDT_SYNC_W-1:0] trig_sync_r;
  logic trig_d_r;
  logic [15:0] cnt_nxt;
  udt_pkg::udt_dir_t dir_nxt;
  logic top_hit;
  logic cmp_hit;
  logic wrap_ev;
  logic reload_ev;
  logic ovf_ev;
  logic cmp_ev;
  logic cap_ev;
  logic pfc;
  logic set_ev;
  logic clr_ev;
  logic [2:0] status_set;

  function automatic logic [15:0] step(input logic [15:0] v,
                                       input logic up);
    step = up ? v + `UDT_ONE : v - `UDT_ONE;
  endfunction : step

  udt_tick_gen u_tick (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .counter_clock_in(counter_clock_in),
    .osc_clock_in(osc_clock_in),
    .use_osc(use_osc),
    .falling_edge_sel(falling_edge_sel),
    .clock_divider_select(clock_divider_select),
    .tick(tick)
  );

  assign pfc = (mode_select == udt_pkg::UDT_PHASE_FREQ_PWM);
  assign top_hit = (count_value == active_top);
  assign cmp_hit = (count_value == active_compare);

  // next count and direction for one counter tick
  always_comb begin
    cnt_nxt = step(count_value, 1'b1);
    dir_nxt = dir_r;
    wrap_ev = 1'b0;
    reload_ev = 1'b0;
    case (mode_select)
      udt_pkg::UDT_PHASE_FREQ_PWM: begin
        if (dir_r == udt_pkg::UDT_DIR_UP) begin
          cnt_nxt = step(count_value, 1'b1);
          if (count_value >= active_top - `UDT_ONE) begin
            dir_nxt = udt_pkg::UDT_DIR_DOWN;
            cnt_nxt = step(count_value, 1'b0);
          end
        end else begin
          cnt_nxt = step(count_value, 1'b0);
          if (count_value == `UDT_ONE) begin
            reload_ev = 1'b1;
            dir_nxt = udt_pkg::UDT_DIR_UP;
          end else if (count_value == `UDT_ZERO) begin
            cnt_nxt = step(count_value, 1'b1);
            dir_nxt = udt_pkg::UDT_DIR_UP;
          end
        end
      end
      default: begin
        dir_nxt = udt_pkg::UDT_DIR_UP;
        if (top_hit) begin
          cnt_nxt = `UDT_ZERO;
          wrap_ev = 1'b1;
          reload_ev = 1'b1;
        end
      end
    endcase
  end

  assign ovf_ev = tick & (wrap_ev | (pfc & reload_ev));
  assign cmp_ev = tick & cmp_hit;
  assign cap_ev = trig_sync_r[1] & ~trig_d_r & capture_enable &
                  (mode_select == udt_pkg::UDT_CLEAR_ON_COMPARE ||
                   mode_select == udt_pkg::UDT_WATCHDOG);
  assign status_set = {cap_ev, cmp_ev, ovf_ev};

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count_value <= `UDT_ZERO;
      dir_r <= udt_pkg::UDT_DIR_UP;
    end else if (!counter_reset_n) begin
      count_value <= `UDT_ZERO;
      dir_r <= udt_pkg::UDT_DIR_UP;
    end else if (tick) begin
      count_value <= cnt_nxt;
      dir_r <= dir_nxt;
    end
  end

  // shadows take host writes; with no host they keep the preload
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      shadow_top_r <= PRELOAD_TOP;
      shadow_compare_r <= PRELOAD_COMPARE;
    end else begin
      if (shadow_top_we) begin
        shadow_top_r <= shadow_top_wdata;
      end
      if (shadow_compare_we) begin
        shadow_compare_r <= shadow_compare_wdata;
      end
    end
  end

  // active top changes only at reload, so a period is never torn; compare also follows the shadow in clear-on-compare and watchdog modes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      active_top <= PRELOAD_TOP;
      active_compare <= PRELOAD_COMPARE;
    end else if (tick & reload_ev) begin
      active_top <= shadow_top_r;
      // compare tracks shadow directly outside pwm modes
      if (mode_select == udt_pkg::UDT_FAST_PWM || pfc) begin
        active_compare <= shadow_compare_r;
      end
    end else if (mode_select == udt_pkg::UDT_CLEAR_ON_COMPARE ||
                 mode_select == udt_pkg::UDT_WATCHDOG) begin
      active_compare <= shadow_compare_r;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      trig_sync_r <= 2'b00;
      trig_d_r <= 1'b0;
    end else begin
      trig_sync_r <= {trig_sync_r[0], capture_trigger};
      trig_d_r <= trig_sync_r[1];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      capture_value <= `UDT_ZERO;
    end else if (cap_ev) begin
      capture_value <= count_value;
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      timer_status <= 3'h0;
    end else begin
      timer_status <= (timer_status & ~status_clear) |
                      status_set;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= |(((timer_status & ~status_clear) | status_set) &
                     {capture_irq_en, compare_irq_en,
                      overflow_irq_en});
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wd_expired <= 1'b0;
    end else begin
      wd_expired <= (mode_select == udt_pkg::UDT_WATCHDOG) & ovf_ev &
                    counter_reset_n;
    end
  end

  // waveform events per mode; default sense sets on set_ev
  always_comb begin
    set_ev = 1'b0;
    clr_ev = 1'b0;
    case (mode_select)
      udt_pkg::UDT_FAST_PWM: begin
        clr_ev = tick & top_hit;
        set_ev = tick & cmp_hit & ~top_hit;
      end
      udt_pkg::UDT_PHASE_FREQ_PWM: begin
        set_ev = cmp_ev & (dir_r == udt_pkg::UDT_DIR_UP);
        clr_ev = cmp_ev & (dir_r == udt_pkg::UDT_DIR_DOWN);
      end
      default: begin
        clr_ev = tick & top_hit;
        set_ev = cmp_ev & ~top_hit;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wave_out <= 1'b0;
    end else begin
      case (output_function)
        udt_pkg::UDT_OUT_LOW: wave_out <= 1'b0;
        udt_pkg::UDT_OUT_TOGGLE: begin
          if (pfc ? cmp_ev : ovf_ev) begin
            wave_out <= ~wave_out;
          end
        end
        udt_pkg::UDT_OUT_WAVE: begin
          if (set_ev) begin
            wave_out <= 1'b1;
          end else if (clr_ev) begin
            wave_out <= 1'b0;
          end
        end
        udt_pkg::UDT_OUT_INV_WAVE: begin
          if (set_ev) begin
            wave_out <= 1'b0;
          end else if (clr_ev) begin
            wave_out <= 1'b1;
          end
        end
        default: wave_out <= 1'b0;
      endcase
    end
  end
endmodule : udt_timer

// ### udt_timer_checker.sv
`timescale 1ns/1ps
module udt_timer_checker (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic counter_reset_n,
  input wire udt_pkg::udt_mode_t mode_select,
  input wire logic capture_enable,
  input wire logic overflow_irq_en,
  input wire logic [2:0] status_clear,
  input wire logic [15:0] count_value,
  input wire logic [15:0] active_top,
  input wire logic [15:0] capture_value,
  input wire logic [2:0] timer_status,
  input wire logic wd_expired,
  input wire logic timer_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic ctc_s;
  logic pfc_s;
  assign ctc_s = mode_select == udt_pkg::UDT_CLEAR_ON_COMPARE;
  assign pfc_s = mode_select == udt_pkg::UDT_PHASE_FREQ_PWM;
  top_reload_a: assert property (
    $changed(active_top) |-> count_value == 16'h0000)
    else $error("top changed off wrap");
  ctc_clear_a: assert property (
    ctc_s && $stable(mode_select) && counter_reset_n &&
    $changed(count_value) && $past(count_value) == $past(active_top)
    |-> count_value == 16'h0000)
    else $error("no clear at top");
  ctc_step_a: assert property (
    ctc_s && $stable(mode_select) && counter_reset_n &&
    $past(counter_reset_n) && $changed(count_value)
    |-> count_value == $past(count_value) + 16'h0001 ||
    count_value == 16'h0000)
    else $error("bad count step");
  wd_pulse_a: assert property (
    wd_expired |=> !wd_expired)
    else $error("expiry not a pulse");
  ovf_sticky_a: assert property (
    timer_status[0] && !status_clear[0] |=> timer_status[0])
    else $error("overflow flag lost");
  irq_merge_a: assert property (
    timer_status[0] && $past(timer_status[0]) && overflow_irq_en &&
    $past(overflow_irq_en) |-> timer_irq)
    else $error("irq missing");
  pfc_turn_a: assert property (
    pfc_s && $stable(mode_select) && count_value > $past(count_value)
    |-> count_value < active_top)
    else $error("no turn at top-1");
  pfc_ovf_a: assert property (
    pfc_s && $stable(mode_select) && $past(count_value) == 16'h0001 &&
    count_value == 16'h0000 |-> ##[0:2] timer_status[0])
    else $error("no overflow at 1-0");
  cap_hold_a: assert property (
    !capture_enable [*4] |=> $stable(capture_value))
    else $error("capture while off");
endmodule : udt_timer_checker

bind udt_timer udt_timer_checker udt_timer_checker_i (.clk_sys(clk_sys),
  .arst_n(arst_n), .counter_reset_n(counter_reset_n),
  .mode_select(mode_select), .capture_enable(capture_enable),
  .overflow_irq_en(overflow_irq_en), .status_clear(status_clear),
  .count_value(count_value), .active_top(active_top),
  .capture_value(capture_value), .timer_status(timer_status),
  .wd_expired(wd_expired), .timer_irq(timer_irq));
